// >>> verilog/anpnp_pkg.sv
/*
  package for the partner ability, expansion and next-page transmit registers.
  assumes a 5-bit management register address and 16-bit register data.
*/
package anpnp_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [4:0] PARTNER_BASE_ABILITIES_OFF = 5'h05;
  localparam logic [4:0] NEGOTIATION_EXPANSION_STATUS_OFF = 5'h06;
  localparam logic [4:0] NEXT_PAGE_TRANSMIT_OFF = 5'h07;
  // ----------------------------------------
  // partner ability fields
  // ----------------------------------------
  localparam int PBA_FURTHER_PAGE_REQUEST = 15;
  localparam int PBA_ACK = 14;
  localparam int PBA_REMOTE_FAULT_FLAG = 13;
  localparam int PBA_RESERVED = 12;
  localparam logic [15:0] PBA_RESET = 16'h0000;
  // ----------------------------------------
  // expansion fields
  // ----------------------------------------
  localparam int EXP_PLACE_SPECIFIED = 6;
  localparam int EXP_STORAGE_PLACE = 5;
  localparam int EXP_PARALLEL_DETECT_FAULT = 4;
  localparam int EXP_PARTNER_EXTRA_PAGE = 3;
  localparam int EXP_LOCAL_EXTRA_PAGE = 2;
  localparam int EXP_PAGE_RECEIVED = 1;
  localparam int EXP_PARTNER_NEGOTIATION = 0;
  // ----------------------------------------
  // next-page transmit fields
  // ----------------------------------------
  localparam int NPT_FURTHER_PAGE_REQUEST = 15;
  localparam int NPT_ACK = 14;
  localparam int NPT_MESSAGE_PAGE_SELECT = 13;
  localparam int NPT_COMPLY_ACKNOWLEDGE = 12;
  localparam int NPT_PAGE_TOGGLE_BIT = 11;
  localparam logic [10:0] NPT_CODE_RESET = 11'h001;
  localparam logic NPT_MESSAGE_PAGE_RESET = 1'b1;
endpackage : anpnp_pkg

// >>> verilog/anpnp_regs.sv
/*
  partner ability, negotiation expansion and next-page transmit registers.
  assumes the arbitration logic on clk_sys drives the status inputs and
  pulses; register access is a plain strobe port with read data one cycle later.
*/
module anpnp_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // from arbitration
  input wire logic partner_page_load,
  input wire logic [15:0] partner_page_word,
  input wire logic partner_ack_seen,
  input wire logic parallel_detect_fault,
  input wire logic partner_extra_page_capable,
  input wire logic partner_negotiation_capable,
  input wire logic page_received_pulse,
  input wire logic tx_ack_seen,
  input wire logic prev_toggle_bit,
  // to arbitration
  output logic [15:0] next_page_word
);
  // ----------------------------------------
  // access decode
  // ----------------------------------------
  logic npt_wr;
  logic exp_rd;

  always_comb begin
    npt_wr = reg_wr && (reg_addr == anpnp_pkg::NEXT_PAGE_TRANSMIT_OFF);
    exp_rd = reg_rd && (reg_addr == anpnp_pkg::NEGOTIATION_EXPANSION_STATUS_OFF);
  end

  // ----------------------------------------
  // partner ability word
  // ----------------------------------------
  logic [15:0] pba_q, pba_d;

  // the load stays open after completion so next pages may rewrite it
  always_comb begin
    pba_d = pba_q;
    if (partner_page_load) begin
      pba_d = partner_page_word;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pba_q <= anpnp_pkg::PBA_RESET;
    end else begin
      pba_q <= pba_d;
    end
  end

  // ----------------------------------------
  // partner acknowledge
  // ----------------------------------------
  logic pba_ack_q, pba_ack_d;

  always_comb begin
    pba_ack_d = partner_ack_seen;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pba_ack_q <= 1'b0;
    end else begin
      pba_ack_q <= pba_ack_d;
    end
  end

  // ----------------------------------------
  // parallel detection fault
  // ----------------------------------------
  logic pdf_q, pdf_d;

  always_comb begin
    pdf_d = parallel_detect_fault;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pdf_q <= 1'b0;
    end else begin
      pdf_q <= pdf_d;
    end
  end

  // ----------------------------------------
  // partner extra page capable
  // ----------------------------------------
  logic lp_np_q, lp_np_d;

  always_comb begin
    lp_np_d = partner_extra_page_capable;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lp_np_q <= 1'b0;
    end else begin
      lp_np_q <= lp_np_d;
    end
  end

  // ----------------------------------------
  // partner negotiation capable
  // ----------------------------------------
  logic lp_an_q, lp_an_d;

  always_comb begin
    lp_an_d = partner_negotiation_capable;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lp_an_q <= 1'b0;
    end else begin
      lp_an_q <= lp_an_d;
    end
  end

  // ----------------------------------------
  // transmit acknowledge
  // ----------------------------------------
  logic tx_ack_q, tx_ack_d;

  always_comb begin
    tx_ack_d = tx_ack_seen;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_ack_q <= 1'b0;
    end else begin
      tx_ack_q <= tx_ack_d;
    end
  end

  // ----------------------------------------
  // page toggle
  // ----------------------------------------
  logic page_toggle_bit_q, page_toggle_bit_d;

  always_comb begin
    page_toggle_bit_d = ~prev_toggle_bit;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      page_toggle_bit_q <= 1'b0;
    end else begin
      page_toggle_bit_q <= page_toggle_bit_d;
    end
  end

  // ----------------------------------------
  // page received flag
  // ----------------------------------------
  logic page_rx_q, page_rx_d;

  always_comb begin
    page_rx_d = page_rx_q;
    if (exp_rd) begin
      page_rx_d = 1'b0;
    end
    // a page landing in the read cycle is kept: the set wins so none is lost
    if (page_received_pulse) begin
      page_rx_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      page_rx_q <= 1'b0;
    end else begin
      page_rx_q <= page_rx_d;
    end
  end

  // ----------------------------------------
  // further page request
  // ----------------------------------------
  logic further_q, further_d;

  // only writable fields take write data; read-only bits keep their flops
  always_comb begin
    further_d = further_q;
    if (npt_wr) begin
      further_d = reg_wdata[anpnp_pkg::NPT_FURTHER_PAGE_REQUEST];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      further_q <= 1'b0;
    end else begin
      further_q <= further_d;
    end
  end

  // ----------------------------------------
  // message page select
  // ----------------------------------------
  logic msg_q, msg_d;

  always_comb begin
    msg_d = msg_q;
    if (npt_wr) begin
      msg_d = reg_wdata[anpnp_pkg::NPT_MESSAGE_PAGE_SELECT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      msg_q <= anpnp_pkg::NPT_MESSAGE_PAGE_RESET;
    end else begin
      msg_q <= msg_d;
    end
  end

  // ----------------------------------------
  // comply acknowledge
  // ----------------------------------------
  logic comply_q, comply_d;

  always_comb begin
    comply_d = comply_q;
    if (npt_wr) begin
      comply_d = reg_wdata[anpnp_pkg::NPT_COMPLY_ACKNOWLEDGE];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      comply_q <= 1'b0;
    end else begin
      comply_q <= comply_d;
    end
  end

  // ----------------------------------------
  // code field
  // ----------------------------------------
  logic [10:0] code_q, code_d;

  always_comb begin
    code_d = code_q;
    if (npt_wr) begin
      code_d = reg_wdata[10:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      code_q <= anpnp_pkg::NPT_CODE_RESET;
    end else begin
      code_q <= code_d;
    end
  end

  // ----------------------------------------
  // read views
  // ----------------------------------------
  logic [15:0] exp_word;
  logic [15:0] pba_word;
  logic [15:0] npt_word;

  always_comb begin
    pba_word = pba_q;
    pba_word[anpnp_pkg::PBA_ACK] = pba_ack_q;
    pba_word[anpnp_pkg::PBA_RESERVED] = 1'b0;
    exp_word = 16'h0000;
    exp_word[anpnp_pkg::EXP_PLACE_SPECIFIED] = 1'b1;
    exp_word[anpnp_pkg::EXP_STORAGE_PLACE] = 1'b1;
    exp_word[anpnp_pkg::EXP_PARALLEL_DETECT_FAULT] = pdf_q;
    exp_word[anpnp_pkg::EXP_PARTNER_EXTRA_PAGE] = lp_np_q;
    exp_word[anpnp_pkg::EXP_LOCAL_EXTRA_PAGE] = 1'b1;
    exp_word[anpnp_pkg::EXP_PAGE_RECEIVED] = page_rx_q;
    exp_word[anpnp_pkg::EXP_PARTNER_NEGOTIATION] = lp_an_q;
    npt_word = {further_q, tx_ack_q, msg_q, comply_q, page_toggle_bit_q, code_q};
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [15:0] rdata_q, rdata_d;

  always_comb begin
    rdata_d = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        anpnp_pkg::PARTNER_BASE_ABILITIES_OFF: rdata_d = pba_word;
        anpnp_pkg::NEGOTIATION_EXPANSION_STATUS_OFF: rdata_d = exp_word;
        anpnp_pkg::NEXT_PAGE_TRANSMIT_OFF: rdata_d = npt_word;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // next page word to arbitration
  // ----------------------------------------
  logic [15:0] npw_q, npw_d;

  // built from next values so arbitration sees a write one cycle after it
  always_comb begin
    npw_d = {further_d, tx_ack_d, msg_d, comply_d, page_toggle_bit_d, code_d};
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      npw_q <= {2'b00, anpnp_pkg::NPT_MESSAGE_PAGE_RESET, 2'b00, anpnp_pkg::NPT_CODE_RESET};
    end else begin
      npw_q <= npw_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata = rdata_q;
  assign next_page_word = npw_q;
endmodule // anpnp_regs

// >>> testbench/anpnp_regs_props.sv
/* assertions on the register block ports.
   assumes one clock and a synchronous reset. */
module anpnp_regs_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic partner_ack_seen,
  input wire logic page_received_pulse,
  input wire logic tx_ack_seen,
  input wire logic prev_toggle_bit,
  input wire logic [15:0] next_page_word
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic r5, r6;
  assign r5 = reg_rd && reg_addr == 5'h05;
  assign r6 = reg_rd && reg_addr == 5'h06;
  property p_fix; $past(r6) |-> reg_rdata[15:5] == 11'h003 && reg_rdata[2]; endproperty
  a_fix: assert property (p_fix) else $error("fixed bits");
  property p_rsv; $past(r5) |-> !reg_rdata[12]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit");
  property p_ack; $past(r5) |-> reg_rdata[14] == $past(partner_ack_seen, 2); endproperty
  a_ack: assert property (p_ack) else $error("ack bit");
  property p_tog; !$past(rst) |-> next_page_word[11] == !$past(prev_toggle_bit); endproperty
  a_tog: assert property (p_tog) else $error("toggle bit");
  property p_txa; !$past(rst) |-> next_page_word[14] == $past(tx_ack_seen); endproperty
  a_txa: assert property (p_txa) else $error("tx ack bit");
  property p_wr; reg_wr && reg_addr == 5'h07 |=>
    (next_page_word & 16'hb7ff) == ($past(reg_wdata) & 16'hb7ff); endproperty
  a_wr: assert property (p_wr) else $error("page write");
  property p_set; page_received_pulse ##1 r6 |=> reg_rdata[1]; endproperty
  a_set: assert property (p_set) else $error("page flag");
  property p_cor; r6 && !page_received_pulse ##1 !page_received_pulse
    ##1 r6 && !page_received_pulse |=> !reg_rdata[1]; endproperty
  a_cor: assert property (p_cor) else $error("clear on read");
  c_wr: cover property (reg_wr && reg_addr == 5'h07);
  c_rx: cover property (page_received_pulse);
  c_rd: cover property (r6);
endmodule // anpnp_regs_props

bind anpnp_regs anpnp_regs_props anpnp_regs_props_inst (.*);

// >>> testbench/anpnp_link_partner.sv
/* link partner model: hands received page words to the block.
   assumes send is a one-cycle request. */
module anpnp_link_partner (
  input wire logic clk_sys,
  input wire logic send,
  input wire logic [15:0] word,
  output logic partner_page_load,
  output logic [15:0] partner_page_word,
  output logic page_received_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  initial partner_page_word = '0;
  always @(posedge clk_sys) begin
    partner_page_load <= send;
    page_received_pulse <= send;
    // idle word churns so a stray load shows
    partner_page_word <= send ? word : ~partner_page_word;
  end
endmodule // anpnp_link_partner

// >>> testbench/anpnp_regs_tb.sv
/* bench for the register block and its link partner model.
   assumes nothing outside; makes clock and reset. */
module anpnp_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, send = 1'b0;
  logic [4:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0, word = '0, reg_rdata, partner_page_word, next_page_word;
  logic [5:0] st = '0;
  logic partner_page_load, page_received_pulse, partner_ack_seen, parallel_detect_fault;
  logic partner_extra_page_capable, partner_negotiation_capable, tx_ack_seen, prev_toggle_bit;
  int error_cnt = 0, samples_checked = 0;
  assign {prev_toggle_bit, tx_ack_seen, partner_negotiation_capable} = st[5:3];
  assign {partner_extra_page_capable, parallel_detect_fault, partner_ack_seen} = st[2:0];
  anpnp_regs anpnp_regs_inst (.*);
  anpnp_link_partner anpnp_link_partner_inst (.*);
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 samples_checked += !w;
    if (!w && reg_rdata !== d) begin
      error_cnt++;
      $display("[FAIL] %0t at %h got %h", $time, a, reg_rdata);
    end
  endtask
  task automatic page(input logic [15:0] w);
    @(posedge clk_sys);
    word <= w;
    send <= 1'b1;
    @(posedge clk_sys);
    send <= 1'b0;
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial forever #4 clk_sys = ~clk_sys;
  initial begin
    repeat (400) @(posedge clk_sys);
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    acc(1'b1, 5'h05, 16'hffff);
    acc(1'b1, 5'h06, 16'hffff);
    acc(1'b1, 5'h1f, 16'hffff);
    acc(1'b0, 5'h05, 16'h0000);
    acc(1'b0, 5'h06, 16'h0064);
    acc(1'b0, 5'h07, 16'h2801);
    acc(1'b0, 5'h1f, 16'h0000);
    acc(1'b1, 5'h07, 16'hffff);
    acc(1'b0, 5'h07, 16'hbfff);
    st <= 6'h30;
    acc(1'b1, 5'h07, 16'h0000);
    acc(1'b0, 5'h07, 16'h4000);
    st <= 6'h0f;
    page(16'hffff);
    acc(1'b0, 5'h06, 16'h007f);
    acc(1'b0, 5'h06, 16'h007d);
    acc(1'b0, 5'h05, 16'hefff);
    st <= 6'h00;
    page(16'h8001);
    acc(1'b0, 5'h05, 16'h8001);
    end_sim();
  end
endmodule // anpnp_regs_tb
